/* File: rtl/pmb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module pmb_top (
  input  wire logic                         sys_clk,
  input  wire logic                         resetn,
  input  wire logic [pmb_pkg::AW-1:0]       reg_addr,
  input  wire logic [pmb_pkg::DW-1:0]       reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [pmb_pkg::DW-1:0]       reg_rdata,
  input  wire logic                         cpu_wait_for_wake,
  input  wire logic [pmb_pkg::N_WSRC-1:0]   wake_evt,
  input  wire logic                         io_wake,
  input  wire logic                         rtc_evt,
  input  wire logic                         ext_rst_wake,
  input  wire logic                         uvlo_rst,
  input  wire logic                         xtal_stable,
  input  wire logic                         cp_form,
  input  wire logic                         fast_rc_div_tgl,
  input  wire logic                         slow_rc_div_tgl,
  input  wire logic                         xtal_ref_tgl,
  output logic                              cpu_clk_en,
  output logic                              cpu_rstn,
  output logic                              boot_mode,
  output logic                              rom_alias_zero,
  output logic                              fast_rc_osc_en,
  output logic                              slow_rc_osc_en,
  output logic                              main_crystal_osc_en,
  output logic                              bandgap_en,
  output logic                              low_current_regulator_en,
  output logic                              rtc_en,
  output logic      [pmb_pkg::N_SRAM-1:0]   sram_pwr_on,
  output logic      [pmb_pkg::N_SRAM-1:0]   sram_ret_lv,
  output logic      [pmb_pkg::N_DOM-1:0]    pwr_dom_en,
  output logic                              clk_fast_sel,
  output logic                              clk_xtal_sel,
  output logic                              dll_en,
  output logic      [1:0]                   dll_sel
);
  import pmb_pkg::*;

  pmb_state_e               state_q, state_d;
  logic [7:0]               cnt_q;
  logic [SYNC_W-1:0]        s;
  logic [2:0]               tgl_q;
  logic [7:2]               ctrl_q;
  logic [DW-1:0]            save_q;
  logic [N_WSRC-1:0]        wake_en_q;
  logic [N_DOM-1:0]         pwr_en_q;
  logic [N_SRAM-1:0]        ret_q;
  logic                     tgt_off_q, por_q, prog_q, from_off_q;
  logic [3:0]               cause_q;
  logic                     cal_busy_q, cal_sel_q;
  logic [4:0]               ref_cnt_q;
  logic [15:0]              cal_res_q;
  logic                     fast_sel_w, xtal_sel_w;
  logic                     wr_ctrl, sleep_go, off_go;
  logic                     cg_wake, slp_wake, off_wake, ent_wake;
  logic                     act_d, slp_d, off_d, ref_e, osc_e;
  logic [DW-1:0]            rd_val;

  pmb_sync #(.W(SYNC_W)) u_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in ({xtal_ref_tgl, slow_rc_div_tgl, fast_rc_div_tgl, cp_form,
                xtal_stable, uvlo_rst, ext_rst_wake, rtc_evt, io_wake}),
    .sync_out (s)
  );

  pmb_clksw u_clksw (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .want_xtal  (ctrl_q[CTRL_XTAL] & (state_q inside {PMB_RUN, PMB_CGATE})),
    .xtal_ok    (s[S_XOK]),
    .fast_sel_q (fast_sel_w),
    .xtal_sel_q (xtal_sel_w)
  );

  assign wr_ctrl  = reg_wr && (reg_addr == OFS_CTRL);
  // sleep beats a wait instruction in the same cycle
  assign sleep_go = wr_ctrl && reg_wdata[CTRL_SLEEP];
  assign off_go   = wr_ctrl && reg_wdata[CTRL_OFF];
  assign cg_wake  = |(wake_evt & wake_en_q);
  // rtc only counts as a wake source while it is kept running
  assign slp_wake = s[S_IO] | (s[S_RTC] & ctrl_q[CTRL_RTC_KEEP]) | s[S_EXT] | s[S_UVLO];
  assign off_wake = s[S_IO] | s[S_EXT] | s[S_UVLO];
  assign ent_wake = (tgt_off_q ? off_wake : slp_wake) | cg_wake;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PMB_RUN: begin
        if (sleep_go || off_go) begin
          state_d = PMB_ENTER;
        end else if (cpu_wait_for_wake) begin
          state_d = PMB_CGATE;
        end
      end
      PMB_CGATE: begin
        if (cg_wake) begin
          state_d = PMB_RUN;
        end
      end
      PMB_ENTER: begin
        if (ent_wake) begin
          state_d = PMB_RUN;
        end else if (cnt_q == ENTRY_CYC - 8'h1) begin
          state_d = tgt_off_q ? PMB_OFF : PMB_SLEEP;
        end
      end
      PMB_SLEEP: begin
        if (slp_wake) begin
          state_d = PMB_WAKE;
        end
      end
      PMB_OFF: begin
        if (off_wake) begin
          state_d = PMB_WAKE;
        end
      end
      PMB_WAKE: begin
        if (cnt_q == WAKE_CYC - 8'h1) begin
          state_d = PMB_RUN;
        end
      end
    endcase
  end

  // power-up goes through the same settle-and-boot path as a wake
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= PMB_WAKE;
      cnt_q   <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_d != state_q) ? 8'h00 : cnt_q + 8'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tgt_off_q  <= 1'b0;
      from_off_q <= 1'b0;
      cause_q    <= 4'h0;
    end else begin
      if (state_q == PMB_RUN && (sleep_go || off_go)) begin
        tgt_off_q <= off_go && !sleep_go;
      end
      if (state_d == PMB_WAKE && state_q != PMB_WAKE) begin
        from_off_q <= (state_q == PMB_OFF);
        cause_q    <= {s[S_UVLO], s[S_EXT], s[S_RTC], s[S_IO]};
      end
    end
  end

  // boot path: cpu held in reset through settle, then fetches boot rom
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      boot_mode      <= 1'b1;
      rom_alias_zero <= 1'b0;
      por_q          <= 1'b1;
      prog_q         <= 1'b0;
    end else begin
      if (state_d == PMB_WAKE) begin
        boot_mode <= 1'b1;
      end else if (reg_wr && reg_addr == OFS_BOOT && reg_wdata[BOOT_DONE]) begin
        boot_mode      <= 1'b0;
        rom_alias_zero <= 1'b0;
      end
      if (state_q == PMB_WAKE && state_d == PMB_RUN && por_q) begin
        rom_alias_zero <= s[S_CP];
        por_q          <= 1'b0;
      end
      if (reg_wr && reg_addr == OFS_BOOT) begin
        prog_q <= reg_wdata[BOOT_PROG];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata[7:2];
    end else if (state_d == PMB_WAKE) begin
      ctrl_q[CTRL_XTAL] <= 1'b0;
    end
  end

  // save register is frozen from entry until the cpu runs again
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      save_q <= SAVE_RST;
    end else if (reg_wr && reg_addr == OFS_SAVE && state_q == PMB_RUN) begin
      save_q <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wake_en_q <= WAKE_EN_RST;
      pwr_en_q  <= PWR_EN_RST;
      ret_q     <= RET_RST;
    end else if (reg_wr) begin
      if (reg_addr == OFS_WAKE_EN) begin
        wake_en_q <= reg_wdata[N_WSRC-1:0];
      end
      if (reg_addr == OFS_PWR_EN) begin
        pwr_en_q <= reg_wdata[N_DOM-1:0];
      end
      if (reg_addr == OFS_RET) begin
        ret_q <= reg_wdata[N_SRAM-1:0];
      end
    end
  end

  // calibration: count rc edges over a fixed number of crystal reference edges
  assign ref_e = s[S_REF] ^ tgl_q[2];
  assign osc_e = cal_sel_q ? (s[S_STGL] ^ tgl_q[1]) : (s[S_FTGL] ^ tgl_q[0]);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tgl_q      <= 3'h0;
      cal_busy_q <= 1'b0;
      cal_sel_q  <= 1'b0;
      ref_cnt_q  <= 5'h00;
      cal_res_q  <= 16'h0000;
    end else begin
      tgl_q <= s[S_REF:S_FTGL];
      if (!cal_busy_q && reg_wr && reg_addr == OFS_CAL && |reg_wdata[1:0]) begin
        cal_busy_q <= 1'b1;
        cal_sel_q  <= reg_wdata[1];
        ref_cnt_q  <= 5'h00;
        cal_res_q  <= 16'h0000;
      end else if (cal_busy_q) begin
        if (osc_e && cal_res_q != 16'hffff) begin
          cal_res_q <= cal_res_q + 16'h1;
        end
        if (ref_e) begin
          ref_cnt_q  <= ref_cnt_q + 5'h01;
          cal_busy_q <= (ref_cnt_q != CAL_REF_LAST);
        end
      end
    end
  end

  assign act_d = state_d inside {PMB_RUN, PMB_CGATE};
  assign slp_d = (state_d == PMB_SLEEP);
  assign off_d = (state_d == PMB_OFF);

  // power switches follow the next state so they line up with state_q
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      fast_rc_osc_en           <= 1'b1;
      slow_rc_osc_en           <= 1'b1;
      main_crystal_osc_en      <= 1'b0;
      bandgap_en               <= 1'b1;
      low_current_regulator_en <= 1'b1;
      rtc_en                   <= 1'b1;
      sram_pwr_on              <= '1;
      sram_ret_lv              <= '0;
      pwr_dom_en               <= '0;
    end else begin
      fast_rc_osc_en           <= !(slp_d || off_d);
      bandgap_en               <= !(slp_d || off_d);
      low_current_regulator_en <= !off_d;
      slow_rc_osc_en           <= off_d ? 1'b0 : (slp_d ? ctrl_q[CTRL_SLOW_KEEP] : 1'b1);
      rtc_en                   <= off_d ? 1'b0 : (slp_d ? ctrl_q[CTRL_RTC_KEEP] : 1'b1);
      main_crystal_osc_en      <= act_d;
      sram_pwr_on              <= off_d ? '0 : (slp_d ? ret_q : '1);
      sram_ret_lv              <= {N_SRAM{slp_d}};
      pwr_dom_en               <= act_d ? pwr_en_q : '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cpu_clk_en   <= 1'b0;
      cpu_rstn     <= 1'b0;
      clk_fast_sel <= 1'b1;
      clk_xtal_sel <= 1'b0;
      dll_en       <= 1'b0;
      dll_sel      <= PMB_DLL_32;
    end else begin
      cpu_clk_en   <= (state_d == PMB_RUN);
      cpu_rstn     <= (state_d != PMB_WAKE);
      clk_fast_sel <= fast_sel_w;
      clk_xtal_sel <= xtal_sel_w;
      dll_en       <= ctrl_q[CTRL_DLL_EN] & xtal_sel_w;
      dll_sel      <= ctrl_q[CTRL_DLL_LSB+1:CTRL_DLL_LSB];
    end
  end

  always_comb begin
    rd_val = '0;
    unique case (reg_addr)
      OFS_CTRL:    rd_val[7:2] = ctrl_q;
      OFS_SAVE:    rd_val = save_q;
      OFS_WAKE_EN: rd_val[N_WSRC-1:0] = wake_en_q;
      OFS_PWR_EN:  rd_val[N_DOM-1:0] = pwr_en_q;
      OFS_RET:     rd_val[N_SRAM-1:0] = ret_q;
      OFS_CAL:     rd_val = {cal_res_q, 14'h0, cal_sel_q, cal_busy_q};
      OFS_STATUS:  rd_val = {16'h0, rom_alias_zero, cause_q, from_off_q, cal_busy_q,
                             s[S_XOK], clk_xtal_sel, boot_mode, state_q};
      OFS_BOOT:    rd_val = {30'h0, prog_q, !boot_mode};
      default:     rd_val = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_val : '0;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_cgate_in;
    (state_q == PMB_RUN && cpu_wait_for_wake && !sleep_go && !off_go)
      |=> (state_q == PMB_CGATE) && !cpu_clk_en;
  endproperty
  a_cgate_in: assert property (p_cgate_in) else $error("wait did not gate cpu");

  property p_cgate_out;
    (state_q == PMB_CGATE && cg_wake) |=> cpu_clk_en && cpu_rstn && state_q == PMB_RUN;
  endproperty
  a_cgate_out: assert property (p_cgate_out) else $error("clock gate wake rebooted");

  property p_cgate_hold;
    (state_q == PMB_CGATE && !cg_wake) |=> state_q == PMB_CGATE;
  endproperty
  a_cgate_hold: assert property (p_cgate_hold) else $error("masked source woke");

  property p_off_wake;
    (state_q == PMB_OFF && !s[S_IO] && !s[S_EXT] && !s[S_UVLO]) |=> state_q == PMB_OFF;
  endproperty
  a_off_wake: assert property (p_off_wake) else $error("off left without source");

  property p_save_frozen;
    (state_q inside {PMB_SLEEP, PMB_OFF, PMB_ENTER}) |=> $stable(save_q);
  endproperty
  a_save_frozen: assert property (p_save_frozen) else $error("save lost in sleep");

  property p_boot_restart;
    (state_q == PMB_WAKE && state_d == PMB_RUN) |=> cpu_rstn && boot_mode && $rose(cpu_rstn);
  endproperty
  a_boot_restart: assert property (p_boot_restart) else $error("no boot after wake");

  property p_sleep_pwr;
    state_q == PMB_SLEEP |-> !fast_rc_osc_en && !bandgap_en && low_current_regulator_en
      && sram_pwr_on == ret_q && &sram_ret_lv;
  endproperty
  a_sleep_pwr: assert property (p_sleep_pwr) else $error("sleep switches wrong");

  property p_off_pwr;
    state_q == PMB_OFF |-> !low_current_regulator_en && !rtc_en && sram_pwr_on == '0;
  endproperty
  a_off_pwr: assert property (p_off_pwr) else $error("off switches wrong");

  property p_dom;
    state_q == PMB_RUN |-> pwr_dom_en == $past(pwr_en_q);
  endproperty
  a_dom: assert property (p_dom) else $error("domain enables wrong");

  property p_abort;
    (state_q == PMB_ENTER && ent_wake) |=> state_q == PMB_RUN;
  endproperty
  a_abort: assert property (p_abort) else $error("wake lost during entry");

  property p_entry_len;
    $rose(state_q == PMB_ENTER) |-> ##[1:10] (state_q != PMB_ENTER);
  endproperty
  a_entry_len: assert property (p_entry_len) else $error("entry too long");

  c_cgate: cover property ((state_q == PMB_CGATE) ##1 (state_q == PMB_RUN));
  c_sleep: cover property ((state_q == PMB_SLEEP) ##1 (state_q == PMB_WAKE));
  c_off: cover property ((state_q == PMB_OFF) ##1 (state_q == PMB_WAKE));
  c_abort: cover property ((state_q == PMB_ENTER) ##1 (state_q == PMB_RUN));
endmodule
`default_nettype wire

/* File: rtl/pmb_pkg.sv */
`default_nettype none
package pmb_pkg;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int SYNC_W = 9;
  localparam int N_SRAM = 5;
  localparam int N_DOM = 8;
  localparam int N_WSRC = 8;
  // clock rate and times
  localparam int SYS_CLK_MHZ = 200;
  localparam int WAKE_SETTLE_NS = 1000;
  localparam int ENTRY_NS = 50;
  localparam int CLKSW_GAP_NS = 20;
  localparam logic [7:0] WAKE_CYC = 8'((WAKE_SETTLE_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [7:0] ENTRY_CYC = 8'((ENTRY_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [3:0] CLKSW_GAP_CYC = 4'((CLKSW_GAP_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [4:0] CAL_REF_LAST = 5'h0f;
  // register offsets
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_SAVE = 8'h04;
  localparam logic [AW-1:0] OFS_WAKE_EN = 8'h08;
  localparam logic [AW-1:0] OFS_PWR_EN = 8'h0c;
  localparam logic [AW-1:0] OFS_RET = 8'h10;
  localparam logic [AW-1:0] OFS_CAL = 8'h14;
  localparam logic [AW-1:0] OFS_STATUS = 8'h18;
  localparam logic [AW-1:0] OFS_BOOT = 8'h1c;
  // control fields
  localparam int CTRL_SLEEP = 0;
  localparam int CTRL_OFF = 1;
  localparam int CTRL_SLOW_KEEP = 2;
  localparam int CTRL_RTC_KEEP = 3;
  localparam int CTRL_XTAL = 4;
  localparam int CTRL_DLL_EN = 5;
  localparam int CTRL_DLL_LSB = 6;
  localparam int BOOT_DONE = 0;
  localparam int BOOT_PROG = 1;
  localparam int CAL_RES_LSB = 16;
  // sync vector positions
  localparam int S_IO = 0;
  localparam int S_RTC = 1;
  localparam int S_EXT = 2;
  localparam int S_UVLO = 3;
  localparam int S_XOK = 4;
  localparam int S_CP = 5;
  localparam int S_FTGL = 6;
  localparam int S_STGL = 7;
  localparam int S_REF = 8;
  // reset values
  localparam logic [7:2] CTRL_RST = 6'h03;
  localparam logic [N_WSRC-1:0] WAKE_EN_RST = 8'hff;
  localparam logic [N_DOM-1:0] PWR_EN_RST = 8'h01;
  localparam logic [N_SRAM-1:0] RET_RST = 5'h1f;
  localparam logic [DW-1:0] SAVE_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    PMB_DLL_32 = 2'h0, PMB_DLL_48 = 2'h1, PMB_DLL_64 = 2'h2, PMB_DLL_96 = 2'h3
  } pmb_dll_e;

  typedef enum logic [5:0] {
    PMB_RUN   = 6'h01,
    PMB_CGATE = 6'h02,
    PMB_ENTER = 6'h04,
    PMB_SLEEP = 6'h08,
    PMB_OFF   = 6'h10,
    PMB_WAKE  = 6'h20
  } pmb_state_e;
endpackage
`default_nettype wire

/* File: rtl/pmb_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module pmb_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/pmb_clksw.sv */
`timescale 1ns/10ps
`default_nettype none
module pmb_clksw
  import pmb_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic want_xtal,
  input  wire logic xtal_ok,
  output logic      fast_sel_q,
  output logic      xtal_sel_q
);
  logic       cur_q;
  logic       tgt;
  logic [3:0] gap_q;

  assign tgt = want_xtal & xtal_ok;

  // break before make: both selects low for a gap before the new one opens
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cur_q      <= 1'b0;
      gap_q      <= 4'h0;
      fast_sel_q <= 1'b1;
      xtal_sel_q <= 1'b0;
    end else if (tgt != cur_q) begin
      fast_sel_q <= 1'b0;
      xtal_sel_q <= 1'b0;
      if (gap_q == CLKSW_GAP_CYC) begin
        cur_q <= tgt;
        gap_q <= 4'h0;
      end else begin
        gap_q <= gap_q + 4'h1;
      end
    end else begin
      gap_q      <= 4'h0;
      fast_sel_q <= ~cur_q;
      xtal_sel_q <= cur_q & xtal_ok;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_no_overlap;
    !(fast_sel_q && xtal_sel_q);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both clock selects on");

  property p_xtal_stable;
    $rose(xtal_sel_q) |-> $past(xtal_ok) && $past(want_xtal);
  endproperty
  a_xtal_stable: assert property (p_xtal_stable) else $error("crystal selected unstable");
endmodule
`default_nettype wire

/* File: testbench/pmb_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pmb_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic       cpu_clk_en,
  input  wire logic       do_wait,
  input  wire logic [7:0] irq_req,
  output logic            cpu_wait_for_wake,
  output logic      [7:0] wake_evt
);
  initial cpu_wait_for_wake = 1'b0;
  initial wake_evt = 8'h00;
  // a stopped core cannot execute another wait instruction
  always @(posedge sys_clk) cpu_wait_for_wake <= do_wait & cpu_clk_en;
  // event lines are levels, held by the caller until the core is back
  always @(posedge sys_clk) wake_evt <= irq_req;
endmodule
`default_nettype wire

/* File: testbench/pmb_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module pmb_top_tb_top;
  import pmb_pkg::*;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        do_wait = 1'b0;
  logic [7:0]  irq_req = 8'h00;
  logic        cpu_wait_for_wake;
  logic [7:0]  wake_evt;
  logic [3:0]  srcs = 4'h0;
  logic        xtal_stable = 1'b0;
  logic        cp = 1'b1;
  logic [2:0]  tgl = 3'h0;
  logic        cpu_clk_en, cpu_rstn, boot_mode, rom_alias_zero, dll_en;
  logic        fast_rc_osc_en, slow_rc_osc_en, main_crystal_osc_en, bandgap_en;
  logic        low_current_regulator_en, rtc_en, clk_fast_sel, clk_xtal_sel;
  logic [4:0]  sram_pwr_on, sram_ret_lv;
  logic [7:0]  pwr_dom_en;
  logic [1:0]  dll_sel;
  logic [14:0] pw;
  logic [4:0]  ret = 5'h1f;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [7:0]  tc [7] = '{8'h0d, 8'h01, 8'h0d, 8'h0d, 8'h02, 8'h02, 8'h02};
  int          ts [7] = '{1, 1, 2, 3, 1, 2, 3};
  bit          tw [7] = '{1, 0, 1, 1, 0, 1, 1};

  assign pw = {fast_rc_osc_en, slow_rc_osc_en, bandgap_en, low_current_regulator_en,
               rtc_en, sram_pwr_on, sram_ret_lv};

  pmb_top u_dut (
    .*,
    .io_wake         (srcs[0]),
    .rtc_evt         (srcs[1]),
    .ext_rst_wake    (srcs[2]),
    .uvlo_rst        (srcs[3]),
    .cp_form         (cp),
    .fast_rc_div_tgl (tgl[0]),
    .slow_rc_div_tgl (tgl[1]),
    .xtal_ref_tgl    (tgl[2])
  );
  pmb_cpu_model u_cpu (.*);

  always #2.5 sys_clk = ~sys_clk;

  task automatic test_done;
    $display("checks %0d bad %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    w(1);
    reg_wr <= 1'b0;
    w(1);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    w(1);
    reg_rd <= 1'b0;
    w(1);
    d = reg_rdata;
    w(1);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk("reg", e, d);
  endtask

  task automatic nap(input logic [7:0] c, input int s, input bit wk);
    logic [31:0] sv;
    int i;
    sv = $urandom;
    wr(OFS_SAVE, sv);
    wr(OFS_CTRL, {24'h0, c});
    w(15);
    chk("pwr", c[1] ? 15'h0 : {1'b0, c[2], 2'b01, c[3], ret, 5'h1f}, pw);
    chk("xo", 1'b0, main_crystal_osc_en);
    srcs[s] <= 1'b1;
    w(20);
    if (!wk) begin
      chk("stay", 1'b0, fast_rc_osc_en);
      srcs[0] <= 1'b1;
      w(20);
    end
    chk("wake", 3'b011, {cpu_rstn, fast_rc_osc_en, clk_fast_sel});
    srcs <= 4'h0;
    for (i = 0; i < 300 && cpu_clk_en !== 1'b1; i++) w(1);
    chk("boot", 2'b11, {cpu_rstn, boot_mode});
    rc(OFS_SAVE, sv);
    wr(OFS_BOOT, 32'h1);
  endtask

  // cut a hang short; both clock selects high is never legal
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    tgl <= {cyc[4], cyc[2], cyc[1]};
    if (clk_fast_sel === 1'b1 && clk_xtal_sel === 1'b1) chk("sel", 2'b00, 2'b11);
    if (cyc == 20000) begin
      miscompares++;
      test_done;
    end
  end

  initial begin
    logic [31:0] d;
    int i;
    int e;
    logic [31:0] hdr [4];
    void'($urandom(78322));
    w(20);
    resetn <= 1'b1;
    for (i = 0; i < 300 && cpu_clk_en !== 1'b1; i++) w(1);
    chk("boot", 4'hf, {cpu_rstn, boot_mode, rom_alias_zero, clk_fast_sel});
    rc(OFS_WAKE_EN, 32'hff);
    rc(OFS_PWR_EN, 32'h1);
    rc(OFS_RET, 32'h1f);
    rc(OFS_SAVE, 32'h0);
    rc(8'h20, 32'h0);
    // header words at 0, 4, 8, c: mode id, code base, code_length_word, boot selector
    hdr[2] = 32'h0;
    wr(OFS_BOOT, (hdr[2] == 32'h0) ? 32'h2 : 32'h1);
    rc(OFS_BOOT, 32'h2);
    hdr[2] = $urandom | 32'h1;
    wr(OFS_BOOT, (hdr[2] == 32'h0) ? 32'h2 : 32'h1);
    w(3);
    chk("leave", 2'b00, {boot_mode, rom_alias_zero});
    d = $urandom;
    wr(OFS_PWR_EN, d);
    w(3);
    chk("dom", d[7:0], pwr_dom_en);
    ret = 5'($urandom_range(31, 1));
    wr(OFS_RET, {27'h0, ret});
    rc(OFS_RET, {27'h0, ret});
    $display("end reset and registers");
    wr(OFS_WAKE_EN, 32'hfe);
    do_wait <= 1'b1;
    w(1);
    do_wait <= 1'b0;
    w(4);
    chk("gate", 1'b0, cpu_clk_en);
    irq_req <= 8'h01;
    w(10);
    chk("mask", 1'b0, cpu_clk_en);
    irq_req <= 8'h01 | (8'h01 << $urandom_range(7, 1));
    w(6);
    chk("resume", 3'b110, {cpu_clk_en, cpu_rstn, boot_mode});
    irq_req <= 8'h00;
    $display("end clock gate");
    wr(OFS_CTRL, 32'h10);
    w(20);
    chk("rc", 2'b10, {clk_fast_sel, clk_xtal_sel});
    xtal_stable <= 1'b1;
    w(20);
    chk("xt", 2'b01, {clk_fast_sel, clk_xtal_sel});
    chk("xo", 1'b1, main_crystal_osc_en);
    for (i = 0; i < 4; i++) begin
      wr(OFS_CTRL, 32'h30 | (i << 6));
      w(3);
      chk("dll", {1'b1, 2'(i)}, {dll_en, dll_sel});
    end
    $display("end clock switch");
    wr(OFS_CTRL, 32'h01);
    srcs <= 4'h1;
    w(30);
    srcs <= 4'h0;
    chk("abort", 4'b1011, {cpu_rstn, boot_mode, cpu_clk_en, fast_rc_osc_en});
    $display("end abort");
    for (i = 0; i < 2; i++) begin
      // start right after a reference edge so the window is exactly 16 reference periods
      while (cyc[3:0] != 4'h2) w(1);
      wr(OFS_CAL, 32'(i + 1));
      d = 32'h1;
      for (int k = 0; k < 150 && d[0] !== 1'b0; k++) rd(OFS_CAL, d);
      e = 128 >> i;
      chk("cal", 1'b1, d[0] === 1'b0 && d[31:16] + 2 >= e && d[31:16] <= e + 2);
    end
    $display("end calibration");
    for (i = 0; i < 7; i++) nap(tc[i], ts[i], tw[i]);
    $display("end sleep and off");
    resetn <= 1'b0;
    cp <= 1'b0;
    w(5);
    resetn <= 1'b1;
    for (i = 0; i < 300 && cpu_clk_en !== 1'b1; i++) w(1);
    chk("cold", 3'b110, {cpu_rstn, boot_mode, rom_alias_zero});
    rc(OFS_SAVE, 32'h0);
    $display("end second reset");
    test_done;
  end
endmodule
`default_nettype wire
